// [core/itsd_map.svh]
/*
  Constants of the interval timer and select decode block: address
  fields, register selects, prescale codes and reset values.
  Assumes inclusion by bare name from the design module.
*/
`ifndef ITSD_MAP_SVH
`define ITSD_MAP_SVH

// address field positions
`define ITSD_A_REGSEL_LSB   0
`define ITSD_A_FLAGSEL      0
`define ITSD_A_TIMER        2
`define ITSD_A_IRQ_EN       3
`define ITSD_A_DEVID_LSB    6
`define ITSD_A_IO_SPACE     9

// port register select in a1..a0
`define ITSD_SEL_PA_DATA    2'h0
`define ITSD_SEL_PA_DIR     2'h1
`define ITSD_SEL_PB_DATA    2'h2
`define ITSD_SEL_PB_DIR     2'h3

// prescale select in a1..a0 on a timer write
`define ITSD_DIV_1          2'h0
`define ITSD_DIV_8          2'h1
`define ITSD_DIV_64         2'h2
`define ITSD_DIV_1024       2'h3

// prescaler reload values (interval length minus one)
`define ITSD_RELOAD_1       10'h000
`define ITSD_RELOAD_8       10'h007
`define ITSD_RELOAD_64      10'h03f
`define ITSD_RELOAD_1024    10'h3ff

// post-flag count stops at minus 255
`define ITSD_COUNT_FLOOR    8'h01
`define ITSD_COUNT_WRAP     8'hff

// flag sits on data bit seven
`define ITSD_FLAG_BIT       7

// reset values
`define ITSD_RST_BYTE       8'h00
`define ITSD_RST_PRESC      10'h000
`define ITSD_RST_PINS       8'hff

// port b bits with other duties
`define ITSD_PB_IRQ_BIT     7
`define ITSD_PB_CS2_BIT     5
`define ITSD_PB_CS1_BIT     6

`endif

// [core/itsd_pkg.sv]
/*
  Types of the interval timer and select decode block.
  Assumes nothing of its surroundings.
*/
package itsd_pkg;

  typedef struct packed {
    logic [9:0] addr;
    logic       rw;
    logic       valid;
    logic       rom_region;
    logic       cs_first;
    logic       cs_second;
    logic [7:0] wdata;
  } itsd_bus_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } itsd_pins_t;

  typedef struct packed {
    logic [7:0] pa_latch;
    logic [7:0] pa_dir;
    logic [7:0] pb_latch;
    logic [7:0] pb_dir;
    logic [7:0] count;
    logic [9:0] presc;
    logic [9:0] reload;
    logic       fast;
    logic       flag;
    logic       irq_en;
    logic [7:0] rdata;
    logic       data_oe_n;
    logic       rom_sel;
    logic       ram_sel;
    itsd_pins_t pa_pins;
    itsd_pins_t pb_pins;
  } itsd_state_t;

endpackage

// [core/itsd_top.sv]
/*
  Interval timer, port registers and chip-level select decode.
  Holds the two port latches and direction registers, the
  prescaled 8-bit interval counter with its flag and interrupt
  enable, and the rom, ram and i/o decode of one device.

  Assumes a processor bus sampled on clk_in with one access per
  cycle in which access_valid_in is high; the ROM and RAM arrays
  live outside and use rom_select_out and ram_select_out.
  Read data, bus enable, selects and pin drives are registered,
  so each answer stands in the one cycle after its access.
  Port pin levels arrive synchronous to clk_in; a released pin
  is expected to be pulled high outside.
  The chip select inputs count only where the matching option
  parameter marks them as selects; otherwise the inputs are
  ignored and those port b pins stay ordinary port pins.
  A flag read reports without clearing; count reads and timer
  writes clear the flag, but a count read in the cycle the flag
  sets leaves it set.
  After the flag the count runs at the clock rate down to minus
  255 and holds there until the next timer write.
  Software must keep address bit three low on reads after the
  flag, or the interrupt output is enabled again.
*/
// Notes on behaviour
// - intervals of 1, 8, 64 or 1024 clocks per count step
// - on timer write, address bits 1..0 choose the interval length
// - timer write loads the data byte as number of intervals
// - before the flag, read returns intervals left, one per interval
// - step after zero sets the flag and count reads all ones
// - after the flag, count drops every clock down to minus 255
// - post-flag read gives elapsed clocks as two's complement
// - write to flag takes count times interval plus one clock
// - any timer write or count read clears the flag; a flag read does not
// - read in the cycle the flag sets leaves it set
// - flag read puts flag on bit seven, rest zero; a0 low reads count
// - every timer access loads interrupt enable from address bit three
// - enabled interrupt with flag set drives port b bit seven low
// - in the i/o space, address bit two picks ports or timer
// - a1..a0 pick port a data, a dir, b data, b dir
// - rom region input splits rom; ram on match, i/o on a9 high
// - each chip select is an independent option, not a port pin
// - both chip selects and rom region decode seven disjoint devices
// - reset zeroes ports, floats data bus, disables interrupt
// - rw high drives read data when addressed, low takes a write
// - direction one drives pin from latch, zero leaves it an input
// - port read gives pins for inputs, latch for outputs
`timescale 1ns/1ps
`default_nettype none
`include "itsd_map.svh"

module itsd_top
  import itsd_pkg::*;
#(
  parameter bit       CS_FIRST_IS_SELECT  = 1'b0,
  parameter bit       CS_SECOND_IS_SELECT = 1'b0,
  // {cs_second, cs_first, rom_region} that selects this device's rom
  parameter bit [2:0] ROM_PATTERN         = 3'h1,
  // a8..a6 that pick this device's ram and i/o space
  parameter bit [2:0] DEVICE_INDEX        = 3'h0
) (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       access_valid_in,
  input  wire logic       rw_in,
  input  wire logic [9:0] addr_in,
  input  wire logic       rom_region_select_in,
  input  wire logic       chip_select_first_in,
  input  wire logic       chip_select_second_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n_out,
  output logic            rom_select_out,
  output logic            ram_select_out,
  input  wire logic [7:0] port_a_pins_in,
  output logic      [7:0] port_a_pins_out,
  output logic      [7:0] port_a_pins_oe_n_out,
  input  wire logic [7:0] port_b_pins_in,
  output logic      [7:0] port_b_pins_out,
  output logic      [7:0] port_b_pins_oe_n_out
);

  if (!CS_FIRST_IS_SELECT && ROM_PATTERN[1]) begin : g_chk_first
    $error("rom pattern needs chip_select_first configured as select");
  end
  if (!CS_SECOND_IS_SELECT && ROM_PATTERN[2]) begin : g_chk_second
    $error("rom pattern needs chip_select_second configured as select");
  end
  // a zero pattern never selects the rom
  if (ROM_PATTERN == 3'h0) begin : g_chk_pattern
    $error("rom pattern must not be all zeros");
  end

  itsd_state_t state;
  itsd_state_t next_state;
  itsd_bus_t   bus;

  assign bus = '{addr:       addr_in,
                 rw:         rw_in,
                 valid:      access_valid_in,
                 rom_region: rom_region_select_in,
                 cs_first:   chip_select_first_in,
                 cs_second:  chip_select_second_in,
                 wdata:      data_in};

  function automatic logic [9:0] div_reload(input logic [1:0] sel);
    logic [9:0] r;
    r = `ITSD_RELOAD_1;
    case (sel)
      `ITSD_DIV_1:    r = `ITSD_RELOAD_1;
      `ITSD_DIV_8:    r = `ITSD_RELOAD_8;
      `ITSD_DIV_64:   r = `ITSD_RELOAD_64;
      `ITSD_DIV_1024: r = `ITSD_RELOAD_1024;
      default:        r = `ITSD_RELOAD_1;
    endcase
    return r;
  endfunction

  // pins for inputs, latch for outputs
  function automatic logic [7:0] port_view(input logic [7:0] pins,
                                           input logic [7:0] latch,
                                           input logic [7:0] dir);
    return (pins & ~dir) | (latch & dir);
  endfunction

  // drive where direction is one, else release to the pull-up
  function automatic itsd_pins_t pin_drive(input logic [7:0] latch,
                                           input logic [7:0] dir);
    itsd_pins_t p;
    p.out  = latch | ~dir;
    p.oe_n = ~dir;
    return p;
  endfunction

  // one count step down
  function automatic logic [7:0] count_dec(input logic [7:0] c);
    return c - 8'h01;
  endfunction

  // flag on data bit seven, other bits zero
  function automatic logic [7:0] flag_byte(input logic f);
    logic [7:0] b;
    b = `ITSD_RST_BYTE;
    b[`ITSD_FLAG_BIT] = f;
    return b;
  endfunction

  // hand a port b pin over to its chip select duty
  function automatic itsd_pins_t release_pin(input itsd_pins_t p,
                                             input int unsigned bit_no);
    itsd_pins_t r;
    r = p;
    r.out[bit_no]  = 1'b1;
    r.oe_n[bit_no] = 1'b1;
    return r;
  endfunction

  // idle state: ports zeroed, pins released high, bus floating
  function automatic itsd_state_t idle_state();
    itsd_state_t s;
    s              = '0;
    s.data_oe_n    = 1'b1;
    s.pa_pins.out  = `ITSD_RST_PINS;
    s.pa_pins.oe_n = `ITSD_RST_PINS;
    s.pb_pins.out  = `ITSD_RST_PINS;
    s.pb_pins.oe_n = `ITSD_RST_PINS;
    return s;
  endfunction

  logic       cs_first_ok;
  logic       cs_second_ok;
  logic       nonrom_cs_ok;
  logic       rom_hit;
  logic       ram_hit;
  logic       io_hit;
  logic       port_hit;
  logic       timer_hit;
  logic [1:0] regsel;
  logic       step;
  logic       flag_set;
  logic       timer_touch;
  logic [7:0] next_rdata;

  always_comb begin
    // a pin kept as a port pin takes no part in decode
    cs_first_ok  = !CS_FIRST_IS_SELECT ||
                   (bus.cs_first == ROM_PATTERN[1]);
    cs_second_ok = !CS_SECOND_IS_SELECT ||
                   (bus.cs_second == ROM_PATTERN[2]);
    nonrom_cs_ok = (!CS_FIRST_IS_SELECT || !bus.cs_first) &&
                   (!CS_SECOND_IS_SELECT || !bus.cs_second);
    regsel = bus.addr[`ITSD_A_REGSEL_LSB +: 2];
    rom_hit   = 1'b0;
    ram_hit   = 1'b0;
    io_hit    = 1'b0;
    if (bus.rom_region == ROM_PATTERN[0] && bus.rom_region &&
        cs_first_ok && cs_second_ok) begin
      rom_hit = 1'b1;
    end else if (bus.rom_region == ROM_PATTERN[0] && !bus.rom_region &&
                 cs_first_ok && cs_second_ok &&
                 ROM_PATTERN[2:1] != 2'h0) begin
      rom_hit = 1'b1;
    end else if (!bus.rom_region && nonrom_cs_ok &&
                 bus.addr[`ITSD_A_DEVID_LSB +: 3] == DEVICE_INDEX) begin
      if (bus.addr[`ITSD_A_IO_SPACE]) begin
        io_hit = 1'b1;
      end else begin
        ram_hit = 1'b1;
      end
    end
    port_hit  = bus.valid && io_hit && !bus.addr[`ITSD_A_TIMER];
    timer_hit = bus.valid && io_hit && bus.addr[`ITSD_A_TIMER];
  end

  always_comb begin
    next_state = state;
    next_rdata = `ITSD_RST_BYTE;
    step       = 1'b0;
    flag_set   = 1'b0;

    // count stepping: prescaled before the flag, every clock after
    if (state.fast) begin
      if (state.count != `ITSD_COUNT_FLOOR) begin
        next_state.count = count_dec(state.count);
      end
    end else begin
      step = (state.presc == `ITSD_RST_PRESC);
      if (step) begin
        next_state.presc = state.reload;
        next_state.count = count_dec(state.count);
        if (state.count == `ITSD_RST_BYTE) begin
          // wraps to all ones as the flag sets
          next_state.count = `ITSD_COUNT_WRAP;
          next_state.fast  = 1'b1;
          flag_set         = 1'b1;
        end
      end else begin
        next_state.presc = state.presc - 10'h001;
      end
    end

    // a timer access is a count read or any timer write
    timer_touch = timer_hit &&
                  (!bus.rw || !bus.addr[`ITSD_A_FLAGSEL]);

    if (timer_hit) begin
      next_state.irq_en = bus.addr[`ITSD_A_IRQ_EN];
    end

    if (timer_hit && !bus.rw) begin
      next_state.count  = bus.wdata;
      next_state.reload = div_reload(regsel);
      // first step one clock after the write
      next_state.presc  = `ITSD_RST_PRESC;
      next_state.fast   = 1'b0;
      flag_set          = 1'b0;
    end

    // set wins over a same-cycle clear
    if (flag_set) begin
      next_state.flag = 1'b1;
    end else if (timer_touch) begin
      next_state.flag = 1'b0;
    end

    // port register writes
    if (port_hit && !bus.rw) begin
      case (regsel)
        `ITSD_SEL_PA_DATA: next_state.pa_latch = bus.wdata;
        `ITSD_SEL_PA_DIR:  next_state.pa_dir   = bus.wdata;
        `ITSD_SEL_PB_DATA: next_state.pb_latch = bus.wdata;
        `ITSD_SEL_PB_DIR:  next_state.pb_dir   = bus.wdata;
        default:           next_state.pa_latch = state.pa_latch;
      endcase
    end

    // read data by select
    if (port_hit) begin
      case (regsel)
        `ITSD_SEL_PA_DATA: next_rdata = port_view(port_a_pins_in,
                                                  state.pa_latch,
                                                  state.pa_dir);
        `ITSD_SEL_PA_DIR:  next_rdata = state.pa_dir;
        `ITSD_SEL_PB_DATA: next_rdata = port_view(port_b_pins_in,
                                                  state.pb_latch,
                                                  state.pb_dir);
        `ITSD_SEL_PB_DIR:  next_rdata = state.pb_dir;
        default:           next_rdata = `ITSD_RST_BYTE;
      endcase
    end else if (timer_hit && bus.addr[`ITSD_A_FLAGSEL]) begin
      next_rdata = flag_byte(state.flag);
    end else if (timer_hit) begin
      next_rdata = state.count;
    end

    next_state.rdata     = next_rdata;
    next_state.data_oe_n = !((port_hit || timer_hit) && bus.rw);
    next_state.rom_sel   = bus.valid && rom_hit;
    next_state.ram_sel   = bus.valid && ram_hit;

    // pins follow the registers as they will stand
    next_state.pa_pins = pin_drive(next_state.pa_latch, next_state.pa_dir);
    next_state.pb_pins = pin_drive(next_state.pb_latch, next_state.pb_dir);
    // interrupt and chip select duties override the port
    if (next_state.irq_en && next_state.flag) begin
      next_state.pb_pins.out[`ITSD_PB_IRQ_BIT]  = 1'b0;
      next_state.pb_pins.oe_n[`ITSD_PB_IRQ_BIT] = 1'b0;
    end
    if (CS_SECOND_IS_SELECT) begin
      next_state.pb_pins = release_pin(next_state.pb_pins,
                                       `ITSD_PB_CS2_BIT);
    end
    if (CS_FIRST_IS_SELECT) begin
      next_state.pb_pins = release_pin(next_state.pb_pins,
                                       `ITSD_PB_CS1_BIT);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= idle_state();
    end else begin
      state <= next_state;
    end
  end

  assign data_out             = state.rdata;
  assign data_oe_n_out        = state.data_oe_n;
  assign rom_select_out       = state.rom_sel;
  assign ram_select_out       = state.ram_sel;
  assign port_a_pins_out      = state.pa_pins.out;
  assign port_a_pins_oe_n_out = state.pa_pins.oe_n;
  assign port_b_pins_out      = state.pb_pins.out;
  assign port_b_pins_oe_n_out = state.pb_pins.oe_n;

endmodule
`default_nettype wire

// [test/itsd_checker.sv]
/* Port assertions for the timer and select decode block.
   Assumes default chip select options and rom pattern. */
`timescale 1ns/1ps
`default_nettype none
module itsd_checker #(
  parameter bit [2:0] DEVICE_INDEX = 3'h0
) (
  input wire logic       clk_in,
  input wire logic       reset_in,
  input wire logic       access_valid_in,
  input wire logic       rw_in,
  input wire logic [9:0] addr_in,
  input wire logic       rom_region_select_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n_out,
  input wire logic       rom_select_out,
  input wire logic       ram_select_out,
  input wire logic [7:0] port_a_pins_out,
  input wire logic [7:0] port_a_pins_oe_n_out,
  input wire logic [7:0] port_b_pins_oe_n_out
);
  logic io_hit;
  logic ram_hit;
  assign io_hit = access_valid_in && !rom_region_select_in &&
                  addr_in[9] && addr_in[8:6] == DEVICE_INDEX;
  assign ram_hit = access_valid_in && !rom_region_select_in &&
                   !addr_in[9] && addr_in[8:6] == DEVICE_INDEX;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  chk_read_drive: assert property (io_hit && rw_in |=> !data_oe_n_out)
    else $error("io read left bus floating");
  chk_bus_float: assert property (!(io_hit && rw_in) |=> data_oe_n_out)
    else $error("bus driven without io read");
  chk_flag_zeros: assert property (io_hit && rw_in && addr_in[2] &&
    addr_in[0] |=> data_out[6:0] == 7'h00)
    else $error("flag read low bits not zero");
  chk_rom_pulse: assert property (access_valid_in && rom_region_select_in
    |=> rom_select_out && !ram_select_out)
    else $error("rom select missing");
  chk_ram_pulse: assert property (ram_hit |=> ram_select_out && !rom_select_out)
    else $error("ram select missing");
  chk_no_stray: assert property (!access_valid_in |=> !rom_select_out &&
    !ram_select_out)
    else $error("select without access");
  chk_reset_idle: assert property ($fell(reset_in) |-> data_oe_n_out &&
    &port_a_pins_oe_n_out && &port_b_pins_oe_n_out)
    else $error("outputs driven after reset");
  chk_released_high: assert property (&(port_a_pins_out |
    ~port_a_pins_oe_n_out))
    else $error("released pin not high");
  chk_latch_drive: assert property (io_hit && !rw_in && addr_in[2:0] == 3'h0
    |-> ##2 ((port_a_pins_out ^ $past(data_in, 2)) & ~port_a_pins_oe_n_out) == 8'h00)
    else $error("driven pin differs from latch");
  cover property (io_hit && rw_in && addr_in[2]);
  cover property (rom_select_out);
  cover property (ram_select_out);
endmodule
bind itsd_top itsd_checker #(.DEVICE_INDEX(DEVICE_INDEX)) u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .access_valid_in(access_valid_in),
  .rw_in(rw_in), .addr_in(addr_in), .data_in(data_in), .data_out(data_out),
  .rom_region_select_in(rom_region_select_in),
  .data_oe_n_out(data_oe_n_out), .rom_select_out(rom_select_out),
  .ram_select_out(ram_select_out), .port_a_pins_out(port_a_pins_out),
  .port_a_pins_oe_n_out(port_a_pins_oe_n_out),
  .port_b_pins_oe_n_out(port_b_pins_oe_n_out));
`default_nettype wire

// [test/itsd_cpu_model.sv]
/* Processor side of the bus: one access per call.
   Assumes read data registered on the taken edge and sampled at the following negedge. */
`timescale 1ns/1ps
`default_nettype none
module itsd_cpu_model
  import itsd_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] data_in,
  input  wire logic       data_oe_n_in,
  input  wire logic       rom_sel_in,
  input  wire logic       ram_sel_in,
  output itsd_bus_t       bus_out
);
  logic [7:0] rd = 8'h00;
  logic       oe_s;
  logic       rom_s;
  logic       ram_s;
  int         tk;
  int         cyc = 0;
  initial bus_out = '0;
  always @(posedge clk_in) cyc <= cyc + 1;
  task automatic acc(input logic rs, input logic rw,
                     input logic [9:0] a, input logic [7:0] wd);
    @(posedge clk_in);
    bus_out <= '{addr: a, rw: rw, valid: 1'b1, rom_region: rs,
                 cs_first: 1'b0, cs_second: 1'b0, wdata: wd};
    @(posedge clk_in);
    bus_out.valid <= 1'b0;
    @(negedge clk_in);
    // released bus shows the inverse of the last byte
    rd = data_oe_n_in ? ~rd : data_in;
    oe_s = data_oe_n_in;
    rom_s = rom_sel_in;
    ram_s = ram_sel_in;
    tk = cyc;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
/* Self-checking bench for the timer and select decode block.
   Assumes default parameters: device index 0, rom on rom region. */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
  begin tests_run++; if ((got) !== (exp)) begin failures++; \
  $display("unexpected %s exp %h got %h", what, exp, got); end end
module tb;
  import itsd_pkg::*;
  localparam int LENS[4] = '{1, 8, 64, 1024};
  logic       clk_in = 1'b0;
  logic       reset_in = 1'b1;
  itsd_bus_t  bus;
  logic [7:0] dout;
  logic       doe_n;
  logic       rom_s;
  logic       ram_s;
  logic [7:0] pa_out, pa_oe_n, pb_out, pb_oe_n;
  logic [7:0] ext_a = 8'hff;
  logic [7:0] ext_b = 8'hff;
  logic [7:0] pa_lvl, pb_lvl;
  int         failures = 0;
  int         tests_run = 0;
  // pins pulled up by the outside world when released
  assign pa_lvl = (pa_oe_n & ext_a) | (~pa_oe_n & pa_out);
  assign pb_lvl = (pb_oe_n & ext_b) | (~pb_oe_n & pb_out);
  always #20 clk_in = ~clk_in;
  itsd_top u_dut (
    .clk_in(clk_in), .reset_in(reset_in), .access_valid_in(bus.valid),
    .rw_in(bus.rw), .addr_in(bus.addr), .rom_region_select_in(bus.rom_region),
    .chip_select_first_in(bus.cs_first), .chip_select_second_in(bus.cs_second),
    .data_in(bus.wdata), .data_out(dout), .data_oe_n_out(doe_n),
    .rom_select_out(rom_s), .ram_select_out(ram_s),
    .port_a_pins_in(pa_lvl), .port_a_pins_out(pa_out),
    .port_a_pins_oe_n_out(pa_oe_n), .port_b_pins_in(pb_lvl),
    .port_b_pins_out(pb_out), .port_b_pins_oe_n_out(pb_oe_n));
  itsd_cpu_model u_cpu (
    .clk_in(clk_in), .data_in(dout), .data_oe_n_in(doe_n),
    .rom_sel_in(rom_s), .ram_sel_in(ram_s), .bus_out(bus));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_reset();
    `CHECK("pa oe_n", 8'hff, pa_oe_n)
    u_cpu.acc(1'b0, 1'b1, 10'h201, 8'h00);
    `CHECK("pa dir", 8'h00, u_cpu.rd)
    u_cpu.acc(1'b0, 1'b1, 10'h203, 8'h00);
    `CHECK("pb dir", 8'h00, u_cpu.rd)
  endtask
  task automatic t_ports();
    u_cpu.acc(1'b0, 1'b0, 10'h201, 8'h0f);
    u_cpu.acc(1'b0, 1'b0, 10'h200, 8'ha5);
    @(posedge clk_in) ext_a <= 8'h3c;
    u_cpu.acc(1'b0, 1'b1, 10'h200, 8'h00);
    `CHECK("pa read", 8'h35, u_cpu.rd)
    `CHECK("pa oe_n", 8'hf0, pa_oe_n)
    u_cpu.acc(1'b0, 1'b0, 10'h203, 8'h0f);
    u_cpu.acc(1'b0, 1'b0, 10'h202, 8'h5a);
    u_cpu.acc(1'b0, 1'b1, 10'h202, 8'h00);
    `CHECK("pb read", 8'hfa, u_cpu.rd)
    u_cpu.acc(1'b0, 1'b1, 10'h203, 8'h00);
    `CHECK("pb dir", 8'h0f, u_cpu.rd)
  endtask
  task automatic t_refuse();
    u_cpu.acc(1'b0, 1'b0, 10'h240, 8'hff);
    u_cpu.acc(1'b0, 1'b1, 10'h241, 8'h00);
    `CHECK("foreign oe_n", 1'b1, u_cpu.oe_s)
    u_cpu.acc(1'b0, 1'b1, 10'h200, 8'h00);
    `CHECK("pa kept", 8'h35, u_cpu.rd)
    u_cpu.acc(1'b1, 1'b1, 10'h000, 8'h00);
    `CHECK("rom sel", 2'b10, {u_cpu.rom_s, u_cpu.ram_s})
    u_cpu.acc(1'b0, 1'b1, 10'h000, 8'h00);
    `CHECK("ram sel", 2'b01, {u_cpu.rom_s, u_cpu.ram_s})
  endtask
  task automatic t_timer();
    int w, j, l;
    for (int d = 0; d < 4; d++) begin
      l = LENS[d];
      u_cpu.acc(1'b0, 1'b0, 10'h204 | 10'(d), 8'h03);
      w = u_cpu.tk;
      do begin
        u_cpu.acc(1'b0, 1'b1, 10'h204, 8'h00);
        j = u_cpu.tk - 1 - w;
        `CHECK("count", 8'(2 - (j - 1) / l), u_cpu.rd)
      end while (j + 2 <= 3 * l);
      u_cpu.acc(1'b0, 1'b1, 10'h205, 8'h00);
      `CHECK("flag", 8'h80, u_cpu.rd)
      `CHECK("no irq", 1'b1, pb_oe_n[7])
      u_cpu.acc(1'b0, 1'b1, 10'h204, 8'h00);
      j = u_cpu.tk - 1 - w;
      `CHECK("elapsed", 8'(255 - (j - 3 * l - 1)), u_cpu.rd)
      u_cpu.acc(1'b0, 1'b1, 10'h205, 8'h00);
      `CHECK("cleared", 8'h00, u_cpu.rd)
    end
  endtask
  task automatic t_irq();
    // shared pin left an input
    u_cpu.acc(1'b0, 1'b0, 10'h203, 8'h00);
    u_cpu.acc(1'b0, 1'b0, 10'h20c, 8'h02);
    repeat (5) @(negedge clk_in);
    `CHECK("irq low", 2'b00, {pb_oe_n[7], pb_out[7]})
    // read with a3 low
    u_cpu.acc(1'b0, 1'b1, 10'h204, 8'h00);
    repeat (2) @(negedge clk_in);
    `CHECK("irq off", 1'b1, pb_oe_n[7])
  endtask
  initial begin
    #(20000 * 40);
    failures++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_ports();
    t_refuse();
    t_timer();
    t_irq();
    test_done();
  end
endmodule
`default_nettype wire
